//--- rtl/eag_pkg.sv
// constants and types shared by the effective address generator
package eag_pkg;
	// address mode field codes
	localparam logic [1:0] EAG_AM_DIRECT = 2'h0;
	localparam logic [1:0] EAG_AM_POSTINC = 2'h1;
	localparam logic [1:0] EAG_AM_DISP = 2'h2;
	localparam logic [1:0] EAG_AM_INDIRECT = 2'h3;
	// field positions, lsb of each field in the 16-bit instruction word
	localparam int EAG_SHORT_RB_LSB = 6;
	localparam int EAG_SHORT_AM_LSB = 4;
	localparam int EAG_LONG_RB_LSB = 8;
	localparam int EAG_SS_AM1_LSB = 4;
	localparam int EAG_SS_AM2_LSB = 2;
	localparam int EAG_SS_RB2_LSB = 6;
	localparam int EAG_RS_REG_LSB = 8;
	localparam int EAG_BSA_RB_LSB = 5;
	localparam int EAG_BSA_IND_BIT = 4;
	localparam int EAG_DISP1_LSB = 8;
	// increment for control-block pointers and the size of one word in bytes
	localparam logic [15:0] EAG_CTL_BLOCK_INC = 16'h0002;
	localparam logic [15:0] EAG_WORD_BYTES = 16'h0002;
	// reset values
	localparam logic [15:0] EAG_RST_WORD = 16'h0000;
	localparam logic [1:0] EAG_RST_LEN = 2'h1;
	// instruction address-argument formats
	typedef enum logic [2:0] {
		EAG_FMT_SHORT,
		EAG_FMT_LONG,
		EAG_FMT_SS,
		EAG_FMT_RS,
		EAG_FMT_BSA
	} eag_fmt_type;
endpackage : eag_pkg

//--- rtl/eag_regfile.sv
// general register file: one write port, one registered read port
`timescale 1ns/1ns
`default_nettype none
module eag_regfile #(
	parameter int NREGS = 8,
	parameter int WIDTH = 16
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_we,
	input wire logic [$clog2(NREGS)-1:0] i_wsel,
	input wire logic [WIDTH-1:0] i_wdata,
	input wire logic [$clog2(NREGS)-1:0] i_rsel,
	output logic [WIDTH-1:0] o_rdata
);
	logic [WIDTH-1:0] mem_q [NREGS];

	// storage cells, cleared on reset so base registers start defined
	generate
		for (genvar g = 0; g < NREGS; g++) begin : g_cell
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					mem_q[g] <= '0;
				end else if (i_we && i_wsel == g) begin
					mem_q[g] <= i_wdata;
				end
			end
		end
	endgenerate

	// read data one cycle after the select; a same-cycle write is not seen
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= '0;
		end else begin
			o_rdata <= mem_q[i_rsel];
		end
	end
endmodule : eag_regfile
`default_nettype wire

//--- rtl/eag_top.sv
// effective address generator: address arguments, base updates, indirection
//
// Function
// - mode 00 uses base register contents as address, register unchanged.
// - mode 01 uses base register, then adds operand byte size to it.
// - mode 01 on a control-block pointer adds exactly two.
// - register-to-storage, same register: increment precedes operand read.
// - storage-to-storage, same register, both 01: increment before and after operand 2.
// - same register, first 01, second not: increment before second address.
// - mode 10 fetches appended word; base zero makes it the address.
// - mode 10 with nonzero base adds base register to appended word.
// - mode 11 base zero reads storage at even appended address.
// - mode 11 nonzero base splits word: upper byte first, lower second.
// - base plus second byte addresses storage; value plus first is address.
// - three-bit base 000 is register 0 in 00/01, none in 10/11.
// - storage-address format: base 000 uses field, else register plus field.
// - storage-address format bit 11 set makes the address indirect.
// - one-word instruction with mode 10 or 11 becomes two words.
// - two-word instruction with mode 10 or 11 becomes three words.
// - short argument has two-bit base for registers 0-3 and two-bit mode.
`timescale 1ns/1ns
`default_nettype none
module eag_top
	import eag_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	// request from the instruction sequencer
	input wire logic i_start,
	input wire eag_fmt_type i_fmt,
	input wire logic [15:0] i_instr,
	input wire logic [15:0] i_next_addr,
	input wire logic i_has_imm,
	input wire logic i_ctl_block,
	input wire logic [2:0] i_op_bytes,
	// general register load port, taken only while idle
	input wire logic i_gr_we,
	input wire logic [2:0] i_gr_sel,
	input wire logic [15:0] i_gr_wdata,
	// main storage read port
	input wire logic i_mem_ack,
	input wire logic [15:0] i_mem_rdata,
	output logic o_mem_req,
	output logic [15:0] o_mem_addr,
	// results
	output logic o_busy,
	output logic o_done,
	output logic [15:0] o_ea1,
	output logic [15:0] o_ea2,
	output logic [15:0] o_reg_operand,
	output logic [15:0] o_imm,
	output logic [1:0] o_len,
	output logic [15:0] o_next_addr
);
	typedef enum logic [3:0] {
		S_IDLE,
		S_ARG,
		S_APP,
		S_RD,
		S_RDW,
		S_CALC,
		S_IND,
		S_NEXT,
		S_OPR,
		S_OPRW,
		S_IMM,
		S_DONE
	} eag_state_type;

	// base register select of an argument; 3 bits, short forms zero-extended
	function automatic logic [2:0] arg_base(input eag_fmt_type f, input logic a,
			input logic [15:0] w);
		logic [2:0] r;
		r = 3'h0;
		unique case (f)
			EAG_FMT_SHORT, EAG_FMT_RS: r = {1'b0, w[EAG_SHORT_RB_LSB +: 2]};
			EAG_FMT_LONG: r = w[EAG_LONG_RB_LSB +: 3];
			EAG_FMT_SS: r = a ? {1'b0, w[EAG_SS_RB2_LSB +: 2]} : w[EAG_LONG_RB_LSB +: 3];
			EAG_FMT_BSA: r = w[EAG_BSA_RB_LSB +: 3];
		endcase
		return r;
	endfunction : arg_base

	// address mode of an argument; the storage-address format acts as mode 10
	function automatic logic [1:0] arg_mode(input eag_fmt_type f, input logic a,
			input logic [15:0] w);
		logic [1:0] m;
		m = EAG_AM_DIRECT;
		unique case (f)
			EAG_FMT_SHORT, EAG_FMT_RS, EAG_FMT_LONG: m = w[EAG_SHORT_AM_LSB +: 2];
			EAG_FMT_SS: m = a ? w[EAG_SS_AM2_LSB +: 2] : w[EAG_SS_AM1_LSB +: 2];
			EAG_FMT_BSA: m = EAG_AM_DISP;
		endcase
		return m;
	endfunction : arg_mode

	logic rst1_q;
	logic rst_n_q;
	eag_state_type state_q;
	eag_fmt_type fmt_q;
	logic [15:0] instr_q;
	logic has_imm_q;
	logic ctl_q;
	logic [2:0] bytes_q;
	logic arg_q;
	logic [15:0] pc_q;
	logic [15:0] app_q;
	logic [15:0] base_q;
	logic [15:0] ea_q;
	logic ind_add_q;
	logic [1:0] len_q;
	logic rf_we;
	logic [2:0] rf_wsel;
	logic [15:0] rf_wdata;
	logic [2:0] rf_rsel;
	logic [15:0] rf_rdata;
	logic [2:0] cur_rb;
	logic [1:0] cur_am;
	logic [15:0] inc;
	logic more_arg;

	// reset release passes two flops so every flop leaves reset together
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst1_q <= 1'b1;
			rst_n_q <= rst1_q;
		end
	end

	// decode of the argument now being worked on
	assign cur_rb = arg_base(fmt_q, arg_q, instr_q);
	assign cur_am = arg_mode(fmt_q, arg_q, instr_q);
	// control blocks step by two whatever their size
	assign inc = ctl_q ? EAG_CTL_BLOCK_INC : {13'h0000, bytes_q};
	assign more_arg = (fmt_q == EAG_FMT_SS) && !arg_q;

	// register file ports: the generator owns the write port while busy
	always_comb begin
		if (state_q == S_CALC && cur_am == EAG_AM_POSTINC) begin
			rf_we = 1'b1;
			rf_wsel = cur_rb;
			// carry out of bit 15 is dropped
			rf_wdata = base_q + inc;
		end else begin
			rf_we = (state_q == S_IDLE) && i_gr_we;
			rf_wsel = i_gr_sel;
			rf_wdata = i_gr_wdata;
		end
		rf_rsel = (state_q == S_OPR) ? instr_q[EAG_RS_REG_LSB +: 3] : cur_rb;
	end

	eag_regfile #(
		.NREGS(8),
		.WIDTH(16)
	) u_regs (
		.i_clk(i_clk),
		.i_rst_n(rst_n_q),
		.i_we(rf_we),
		.i_wsel(rf_wsel),
		.i_wdata(rf_wdata),
		.i_rsel(rf_rsel),
		.o_rdata(rf_rdata)
	);

	// request capture; inputs are held only in the start cycle
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			fmt_q <= EAG_FMT_SHORT;
			instr_q <= EAG_RST_WORD;
			has_imm_q <= 1'b0;
			ctl_q <= 1'b0;
			bytes_q <= 3'h0;
		end else if (state_q == S_IDLE && i_start) begin
			fmt_q <= i_fmt;
			instr_q <= i_instr;
			has_imm_q <= i_has_imm;
			ctl_q <= i_ctl_block;
			bytes_q <= i_op_bytes;
		end
	end

	// sequencer: arguments are handled in order, so each base update is
	// visible to every later read of the same register
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= S_IDLE;
			arg_q <= 1'b0;
		end else begin
			unique case (state_q)
				S_IDLE: if (i_start) begin
					state_q <= S_ARG;
					arg_q <= 1'h0;
				end
				// modes 10 and 11 bring an appended word
				S_ARG: state_q <= cur_am[1] ? S_APP : S_RD;
				// storage may stall, so every storage step waits for its acknowledge
				S_APP: state_q <= i_mem_ack ? S_RD : S_APP;
				S_RD: state_q <= S_RDW;
				S_RDW: state_q <= S_CALC;
				S_CALC: begin
					if (cur_am == EAG_AM_INDIRECT) begin
						state_q <= S_IND;
					end else if (fmt_q == EAG_FMT_BSA && instr_q[EAG_BSA_IND_BIT]) begin
						state_q <= S_IND;
					end else begin
						state_q <= S_NEXT;
					end
				end
				S_IND: state_q <= i_mem_ack ? S_NEXT : S_IND;
				S_NEXT: begin
					if (more_arg) begin
						// second argument rereads the base after any increment
						state_q <= S_ARG;
						arg_q <= 1'b1;
					end else if (fmt_q == EAG_FMT_RS) begin
						state_q <= S_OPR;
					end else if (has_imm_q) begin
						state_q <= S_IMM;
					end else begin
						state_q <= S_DONE;
					end
				end
				S_OPR: state_q <= S_OPRW;
				S_OPRW: state_q <= has_imm_q ? S_IMM : S_DONE;
				S_IMM: state_q <= i_mem_ack ? S_DONE : S_IMM;
				S_DONE: state_q <= S_IDLE;
			endcase
		end
	end

	// fetch pointer and instruction length in words
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pc_q <= EAG_RST_WORD;
			len_q <= EAG_RST_LEN;
		end else if (state_q == S_IDLE && i_start) begin
			pc_q <= i_next_addr;
			len_q <= EAG_RST_LEN;
		end else if ((state_q == S_APP || state_q == S_IMM) && i_mem_ack) begin
			// appended words come first, the immediate word after them
			pc_q <= pc_q + EAG_WORD_BYTES;
			len_q <= len_q + 2'h1;
		end
	end

	// appended word and base register value of the current argument
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			app_q <= EAG_RST_WORD;
			base_q <= EAG_RST_WORD;
		end else begin
			if (state_q == S_APP && i_mem_ack) begin
				app_q <= i_mem_rdata;
			end
			if (state_q == S_RDW) begin
				base_q <= rf_rdata;
			end
		end
	end

	// effective address of the current argument
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ea_q <= EAG_RST_WORD;
			ind_add_q <= 1'b0;
		end else if (state_q == S_CALC) begin
			ind_add_q <= 1'b0;
			unique case (cur_am)
				EAG_AM_DIRECT, EAG_AM_POSTINC: ea_q <= base_q;
				EAG_AM_DISP: begin
					// base 000 selects no register in modes 10 and 11
					if (cur_rb == 3'h0) begin
						ea_q <= app_q;
					end else begin
						ea_q <= base_q + app_q;
					end
				end
				EAG_AM_INDIRECT: begin
					if (cur_rb == 3'h0) begin
						ea_q <= {app_q[15:1], 1'b0};
					end else begin
						// second displacement is the low byte, unsigned
						ea_q <= base_q + {8'h00, app_q[7:0]};
						ind_add_q <= 1'b1;
					end
				end
			endcase
		end else if (state_q == S_IND && i_mem_ack) begin
			if (ind_add_q) begin
				ea_q <= i_mem_rdata + {8'h00, app_q[EAG_DISP1_LSB +: 8]};
			end else begin
				ea_q <= i_mem_rdata;
			end
		end
	end

	// storage requests stand until the acknowledge cycle
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_mem_req <= 1'b0;
			o_mem_addr <= EAG_RST_WORD;
		end else if (o_mem_req) begin
			if (i_mem_ack) begin
				o_mem_req <= 1'b0;
			end
		end else if (state_q == S_ARG && cur_am[1]) begin
			o_mem_req <= 1'b1;
			o_mem_addr <= pc_q;
		end else if (state_q == S_NEXT && !more_arg && fmt_q != EAG_FMT_RS && has_imm_q) begin
			o_mem_req <= 1'b1;
			o_mem_addr <= pc_q;
		end else if (state_q == S_OPRW && has_imm_q) begin
			o_mem_req <= 1'b1;
			o_mem_addr <= pc_q;
		end else if (state_q == S_CALC && cur_am == EAG_AM_INDIRECT) begin
			o_mem_req <= 1'b1;
			// same value the address register takes in this cycle
			o_mem_addr <= (cur_rb == 3'h0) ? {app_q[15:1], 1'b0} : base_q + {8'h00, app_q[7:0]};
		end else if (state_q == S_CALC && fmt_q == EAG_FMT_BSA && instr_q[EAG_BSA_IND_BIT]) begin
			o_mem_req <= 1'b1;
			o_mem_addr <= (cur_rb == 3'h0) ? app_q : base_q + app_q;
		end
	end

	// result outputs
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_ea1 <= EAG_RST_WORD;
			o_ea2 <= EAG_RST_WORD;
			o_reg_operand <= EAG_RST_WORD;
			o_imm <= EAG_RST_WORD;
		end else begin
			if (state_q == S_NEXT && !arg_q) begin
				o_ea1 <= ea_q;
			end
			if (state_q == S_NEXT && arg_q) begin
				o_ea2 <= ea_q;
			end
			if (state_q == S_OPRW) begin
				// read after the base write, so an aliased register is stepped
				o_reg_operand <= rf_rdata;
			end
			if (state_q == S_IMM && i_mem_ack) begin
				o_imm <= i_mem_rdata;
			end
		end
	end

	// status outputs
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_len <= EAG_RST_LEN;
			o_next_addr <= EAG_RST_WORD;
		end else begin
			o_busy <= (state_q == S_IDLE) ? i_start : (state_q != S_DONE);
			o_done <= (state_q == S_DONE);
			if (state_q == S_DONE) begin
				o_len <= len_q;
				o_next_addr <= pc_q;
			end
		end
	end
endmodule : eag_top
`default_nettype wire

//--- tb/eag_top_assertions.sv
// concurrent checks on the effective address generator ports
`timescale 1ns/1ns
`default_nettype none
module eag_top_checker
	import eag_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_start,
	input wire eag_fmt_type i_fmt,
	input wire logic [15:0] i_instr,
	input wire logic [15:0] i_next_addr,
	input wire logic i_has_imm,
	input wire logic i_mem_ack,
	input wire logic [15:0] i_mem_rdata,
	input wire logic o_mem_req,
	input wire logic [15:0] o_mem_addr,
	input wire logic o_busy,
	input wire logic o_done,
	input wire logic [15:0] o_ea1,
	input wire logic [1:0] o_len,
	input wire logic [15:0] o_next_addr
);
	logic [15:0] nxt_q;
	logic [15:0] word_q;
	logic [1:0] acks_q;
	logic take;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	assign take = i_start && !o_busy && !o_done;
	// where appended words start, and the first word storage returned
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			nxt_q <= 16'h0000;
			word_q <= 16'h0000;
			acks_q <= 2'h0;
		end else if (take) begin
			nxt_q <= i_next_addr;
			acks_q <= 2'h0;
		end else if (o_mem_req && i_mem_ack && acks_q != 2'h3) begin
			acks_q <= acks_q + 2'h1; // saturates so a long fetch chain never looks fresh
			if (acks_q == 2'h0) word_q <= i_mem_rdata;
		end
	end
	busy_on_start_a: assert property (take |=> o_busy)
		else $error("busy missing after start");
	quiet_start_a: assert property (take |=> !o_done [*5])
		else $error("done came too early");
	done_pulse_a: assert property (o_done |-> $past(o_busy) && !o_busy ##1 !o_done)
		else $error("done pulse or busy drop wrong");
	req_hold_a: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
		else $error("storage request not held");
	req_drop_a: assert property (o_mem_req && i_mem_ack |=> !o_mem_req)
		else $error("storage request not released");
	req_busy_a: assert property (o_mem_req |-> o_busy && !o_done)
		else $error("storage request outside generation");
	first_fetch_a: assert property (
		o_mem_req && acks_q == 2'h0 |-> o_mem_addr == nxt_q)
		else $error("first fetch not at next word");
	length_a: assert property (
		o_done |-> o_len != 2'h0 && o_next_addr == nxt_q + {13'h0, o_len - 2'h1, 1'h0})
		else $error("length and next address disagree");
	short_len_a: assert property (
		o_done && i_fmt == EAG_FMT_SHORT && !i_has_imm |-> o_len == (i_instr[5] ? 2'h2 : 2'h1))
		else $error("short form length wrong");
	disp_word_a: assert property (
		o_done && i_fmt == EAG_FMT_SHORT && i_instr[7:4] == 4'h2 |-> o_ea1 == word_q)
		else $error("appended word not used as address");
endmodule : eag_top_checker
bind eag_top eag_top_checker i_chk (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_start(i_start),
	.i_fmt(i_fmt), .i_instr(i_instr), .i_next_addr(i_next_addr), .i_has_imm(i_has_imm),
	.i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .o_mem_req(o_mem_req),
	.o_mem_addr(o_mem_addr), .o_busy(o_busy), .o_done(o_done), .o_ea1(o_ea1),
	.o_len(o_len), .o_next_addr(o_next_addr));
`default_nettype wire

//--- tb/eag_storage_model.sv
// main storage model answering the generator's word reads
`timescale 1ns/1ns
`default_nettype none
module eag_storage_model (
	input wire logic i_clk,
	input wire logic i_req,
	input wire logic [15:0] i_addr,
	input wire logic i_slow,
	output logic o_ack,
	output logic [15:0] o_rdata
);
	logic [15:0] mem [logic [15:0]];
	logic [1:0] wait_q;
	initial begin
		o_ack = 1'h0;
		o_rdata = 16'h5A5A;
		wait_q = 2'h0;
	end
	// one-cycle ack after an optional stall; data toggles outside the ack so a
	// sample of the bus one cycle late can never match by luck
	always @(posedge i_clk) begin
		o_ack <= 1'h0;
		o_rdata <= ~o_rdata;
		if (i_req && !o_ack) begin
			if (wait_q == 2'h0) begin
				o_ack <= 1'h1;
				o_rdata <= mem.exists(i_addr) ? mem[i_addr] : ~i_addr;
				wait_q <= i_slow ? 2'h3 : 2'h0;
			end else begin
				wait_q <= wait_q - 2'h1;
			end
		end
	end
endmodule : eag_storage_model
`default_nettype wire

//--- tb/eag_top_bench.sv
// self-checking bench for the effective address generator
`timescale 1ns/1ns
`default_nettype none
module eag_top_bench
	import eag_pkg::*;
;
	logic i_clk, i_arst_n, i_start, i_has_imm, i_ctl_block, i_gr_we, i_mem_ack, slow;
	logic o_mem_req, o_busy, o_done;
	eag_fmt_type i_fmt;
	logic [15:0] i_instr, i_next_addr, i_gr_wdata, i_mem_rdata, o_mem_addr;
	logic [15:0] o_ea1, o_ea2, o_reg_operand, o_imm, o_next_addr;
	logic [2:0] i_op_bytes, i_gr_sel;
	logic [1:0] o_len;
	logic [15:0] rv [8];
	int err_total, num_checks, cyc;
	eag_top i_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_start(i_start), .i_fmt(i_fmt),
		.i_instr(i_instr), .i_next_addr(i_next_addr), .i_has_imm(i_has_imm),
		.i_ctl_block(i_ctl_block), .i_op_bytes(i_op_bytes), .i_gr_we(i_gr_we),
		.i_gr_sel(i_gr_sel), .i_gr_wdata(i_gr_wdata), .i_mem_ack(i_mem_ack),
		.i_mem_rdata(i_mem_rdata), .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr),
		.o_busy(o_busy), .o_done(o_done), .o_ea1(o_ea1), .o_ea2(o_ea2),
		.o_reg_operand(o_reg_operand), .o_imm(o_imm), .o_len(o_len), .o_next_addr(o_next_addr));
	eag_storage_model i_mem (.i_clk(i_clk), .i_req(o_mem_req), .i_addr(o_mem_addr),
		.i_slow(slow), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
	initial begin
		i_clk = 1'h0;
		forever #20 i_clk = ~i_clk;
	end
	// a hang ends the run as a failure instead of spinning forever
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			finish_test();
		end
	end
	task automatic finish_test();
		if (err_total == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic set_reg(input logic [2:0] r, input logic [15:0] v);
		@(posedge i_clk);
		i_gr_we <= 1'h1;
		i_gr_sel <= r;
		i_gr_wdata <= v;
		@(posedge i_clk);
		i_gr_we <= 1'h0;
	endtask : set_reg
	// fl packs immediate flag, control-block flag and operand bytes
	task automatic run(input eag_fmt_type f, input logic [15:0] ins, input logic [15:0] na,
		input logic [4:0] fl);
		@(posedge i_clk);
		i_start <= 1'h1;
		i_fmt <= f;
		i_instr <= ins;
		i_next_addr <= na;
		i_has_imm <= fl[4];
		i_ctl_block <= fl[3];
		i_op_bytes <= fl[2:0];
		@(posedge i_clk);
		i_start <= 1'h0;
		repeat (80) begin
			@(posedge i_clk);
			#1;
			if (o_done === 1'h1) break;
		end
		chk({15'h0, o_done}, 16'h1);
	endtask : run
	// a long-form mode 00 generation exposes a register without touching it
	task automatic reg_is(input logic [2:0] r, input logic [15:0] v);
		run(EAG_FMT_LONG, {5'h0, r, 8'h00}, 16'h0200, 5'h02);
		chk(o_ea1, v);
	endtask : reg_is
	task automatic wm(input logic [15:0] a, input logic [15:0] v);
		i_mem.mem[a] = v;
	endtask : wm
	initial begin
		{i_arst_n, i_start, i_has_imm, i_ctl_block, i_gr_we, slow} = 6'h00;
		{i_instr, i_next_addr, i_gr_wdata, i_op_bytes, i_gr_sel} = 54'h0;
		i_fmt = EAG_FMT_SHORT;
		rv = '{16'h0200, 16'h0080, 16'h0535, 16'h0800, 16'h0100, 16'hFFFF, 16'h0000, 16'h1000};
		repeat (12) @(posedge i_clk);
		i_arst_n <= 1'h1;
		repeat (3) @(posedge i_clk);
		for (int k = 0; k < 8; k++) set_reg(3'(k), rv[k]);
		run(EAG_FMT_SHORT, 16'h0040, 16'h0100, 5'h02);
		chk(o_ea1, rv[1]);
		chk({14'h0, o_len}, 16'h1);
		reg_is(3'h1, rv[1]);
		for (int k = 0; k < 3; k++) begin
			run(EAG_FMT_SHORT, 16'h0050, 16'h0100, {2'h0, 3'h1 << k});
			chk(o_ea1, rv[1]);
			rv[1] += 16'h1 << k;
		end
		reg_is(3'h1, rv[1]);
		run(EAG_FMT_SHORT, 16'h0050, 16'h0100, 5'h0C);
		chk(o_ea1, rv[1]);
		rv[1] += 16'h2;
		reg_is(3'h1, rv[1]);
		run(EAG_FMT_LONG, 16'h0510, 16'h0100, 5'h02);
		chk(o_ea1, 16'hFFFF);
		reg_is(3'h5, 16'h0001);
		slow = 1'h1;
		wm(16'h0300, 16'h1234);
		run(EAG_FMT_SHORT, 16'h0020, 16'h0300, 5'h02);
		chk(o_ea1, 16'h1234);
		chk(o_next_addr, 16'h0302);
		wm(16'h0300, 16'h0100);
		run(EAG_FMT_SHORT, 16'h00E0, 16'h0300, 5'h02);
		chk(o_ea1, 16'h0900);
		wm(16'h0300, 16'h0051);
		wm(16'h0050, 16'h0400);
		run(EAG_FMT_SHORT, 16'h0030, 16'h0300, 5'h02);
		chk(o_ea1, 16'h0400);
		wm(16'h0300, 16'h2542);
		wm(16'h0577, 16'h0410);
		run(EAG_FMT_SHORT, 16'h00B0, 16'h0300, 5'h02);
		chk(o_ea1, 16'h0435);
		slow = 1'h0;
		wm(16'h0300, 16'h0444);
		wm(16'h0444, 16'h0666);
		run(EAG_FMT_LONG, 16'h0020, 16'h0300, 5'h02);
		chk(o_ea1, 16'h0444);
		run(EAG_FMT_LONG, 16'h0030, 16'h0300, 5'h02);
		chk(o_ea1, 16'h0666);
		run(EAG_FMT_LONG, 16'h0720, 16'h0300, 5'h02);
		chk(o_ea1, 16'h1444);
		reg_is(3'h0, rv[0]);
		wm(16'h0300, 16'h0410);
		wm(16'h0510, 16'h0640);
		run(EAG_FMT_BSA, 16'h0000, 16'h0300, 5'h02);
		chk(o_ea1, 16'h0410);
		run(EAG_FMT_BSA, 16'h0080, 16'h0300, 5'h02);
		chk(o_ea1, 16'h0510);
		run(EAG_FMT_BSA, 16'h0090, 16'h0300, 5'h02);
		chk(o_ea1, 16'h0640);
		wm(16'h0300, 16'h0100);
		wm(16'h0302, 16'hBEEF);
		run(EAG_FMT_SHORT, 16'h00E0, 16'h0300, 5'h12);
		chk(o_imm, 16'hBEEF);
		chk({14'h0, o_len}, 16'h3);
		run(EAG_FMT_SHORT, 16'h0040, 16'h0300, 5'h12);
		chk(o_imm, 16'h0100);
		run(EAG_FMT_RS, 16'h03D0, 16'h0300, 5'h02);
		chk(o_ea1, 16'h0800);
		chk(o_reg_operand, 16'h0802);
		run(EAG_FMT_SS, 16'h0154, 16'h0300, 5'h02);
		chk(o_ea1, rv[1]);
		chk(o_ea2, rv[1] + 16'h2);
		rv[1] += 16'h4;
		reg_is(3'h1, rv[1]);
		wm(16'h0300, 16'h0010);
		run(EAG_FMT_SS, 16'h0158, 16'h0300, 5'h02);
		chk(o_ea2, rv[1] + 16'h0012);
		rv[1] += 16'h2;
		reg_is(3'h1, rv[1]);
		finish_test();
	end
endmodule : eag_top_bench
`default_nettype wire
